// ===== hw/spi_port_map.svh
/*
  Constants of the serial port: mode codes, control bit positions, reset values and rates.
  Assumes inclusion by bare name; definitions only.
*/
`ifndef SPI_PORT_MAP_SVH
`define SPI_PORT_MAP_SVH
`define MODE_MASTER_DIV4    4'h0
`define MODE_MASTER_DIV16   4'h1
`define MODE_MASTER_DIV64   4'h2
`define MODE_MASTER_TIMER   4'h3
`define MODE_SLAVE_SELECT   4'h4
`define MODE_SLAVE_FREE     4'h5
`define CTRL_ENABLE_BIT     5
`define CTRL_POLARITY_BIT   4
`define STAT_SAMPLE_BIT     7
`define STAT_EDGE_BIT       6
`define DIV4_HALF           6'h01
`define DIV16_HALF          6'h07
`define DIV64_HALF          6'h1f
`define BYTE_RESET          8'h00
`define BIT_LAST            3'h7
`endif

// ===== hw/spi_port_pkg.sv
/*
  Types shared by the serial port files.
  Assumes the map header is included alongside where constants are needed.
*/
package spi_port_pkg;
  typedef enum logic [1:0] {IDLE, LEAD, TRAIL} master_state_t;
  typedef logic [7:0] byte_t;
endpackage

// ===== hw/pin_sync.sv
/*
  Two-flop synchroniser for the external serial pins.
  Assumes inputs asynchronous to clk_sys.
*/
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1Reg;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      stage1Reg <= '0;
      syncOut   <= '0;
    end else begin
      stage1Reg <= asyncIn;
      syncOut   <= stage1Reg;
    end
  end
endmodule

// ===== hw/rate_divider.sv
/*
  Master bit-clock tick generator: a tick every half bit period.
  Assumes timerTick is a one-cycle pulse from the period timer on clk_sys.
*/
`timescale 1ns/1ps
`include "spi_port_map.svh"
module rate_divider (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       run,
  input  wire logic [3:0] modeSel,
  input  wire logic       timerTick,
  output logic            halfTick
);
  logic [5:0] countReg;
  logic [5:0] limit;
  always_comb begin
    unique case (modeSel)
      `MODE_MASTER_DIV16: limit = `DIV16_HALF;
      `MODE_MASTER_DIV64: limit = `DIV64_HALF;
      default:            limit = `DIV4_HALF;
    endcase
  end
  // Timer rate: each timer pulse is half a bit, so the bit runs at timer output / 2
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !run) begin
      countReg <= '0;
      halfTick <= 1'b0;
    end else if (modeSel == `MODE_MASTER_TIMER) begin
      countReg <= '0;
      halfTick <= timerTick;
    end else if (countReg == limit) begin
      countReg <= '0;
      halfTick <= 1'b1;
    end else begin
      countReg <= countReg + 6'h01;
      halfTick <= 1'b0;
    end
  end
endmodule

// ===== hw/spi_master_slave_port.sv
/*
  Eight-bit serial port engine: master or slave, one shift register and a receive buffer.
  Assumes CPU strobes on clk_sys, serial pins asynchronous; settings held stable while enabled.
*/
`timescale 1ns/1ps
`include "spi_port_map.svh"
module spi_master_slave_port
  import spi_port_pkg::*;
(
  input  wire logic                clk_sys,
  input  wire logic                rst_n,
  input  wire logic                portEnable,
  input  wire logic                clockIdlePolarity,
  input  wire logic [3:0]          portModeSelect,
  input  wire logic                inputSamplePhase,
  input  wire logic                clockEdgeSelect,
  input  wire logic                sleepActive,
  input  wire logic                timerTick,
  input  wire logic                bufWrite,
  input  wire spi_port_pkg::byte_t bufWriteData,
  input  wire logic                bufRead,
  input  wire logic                irqClear,
  input  wire logic                collisionClear,
  input  wire logic                sdiPin,
  input  wire logic                sckPinIn,
  input  wire logic                selectPin_n,
  output spi_port_pkg::byte_t      portDataBuffer,
  output logic                     bufferFullFlag,
  output logic                     portIrqFlag,
  output logic                     writeCollisionFlag,
  output logic                     wakeRequest,
  output logic                     busy,
  output logic                     sdoOut,
  output logic                     sdoOe_n,
  output logic                     sckOut,
  output logic                     sckOe_n
);
  import spi_port_pkg::*;

  logic [2:0]    syncPins;
  logic          sdiSync;
  logic          sckSync;
  logic          selSync_n;
  logic          sckPrevReg;
  byte_t         portShiftReg;
  logic [2:0]    bitCountReg;
  logic          sampledBitReg;
  logic          activeReg;
  master_state_t mStateReg;
  logic          halfTick;
  logic          isMaster;
  logic          selMode;
  logic          slaveHold;
  logic          sckRise;
  logic          sckFall;
  logic          leadEdge;
  logic          trailEdge;
  logic          sampleEvt;
  logic          shiftEvt;
  logic          lastSample;
  logic          byteDone;
  logic          acceptWrite;
  logic          xferBusy;

  pin_sync #(.WIDTH(3)) u_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .asyncIn ({sdiPin, sckPinIn, selectPin_n}),
    .syncOut (syncPins)
  );
  assign sdiSync   = syncPins[2];
  assign sckSync   = syncPins[1];
  assign selSync_n = syncPins[0];


  // Codes 0 to 3 are the master rates; everything above is a slave role
  assign isMaster = portModeSelect <= `MODE_MASTER_TIMER;
  assign selMode  = portModeSelect == `MODE_SLAVE_SELECT;
  // Bit count and slave activity held in reset while disabled or deselected
  assign slaveHold = !portEnable || (selMode && selSync_n);


  // Divider stops with the transfer, so each byte in the divided modes starts on a full half bit; timer mode follows the free-running timer pulse
  rate_divider u_rate (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .run       (portEnable && isMaster && activeReg && !sleepActive),
    .modeSel   (portModeSelect),
    .timerTick (timerTick),
    .halfTick  (halfTick)
  );

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sckPrevReg <= 1'b0;
    end else begin
      sckPrevReg <= sckSync;
    end
  end
  assign sckRise = sckSync && !sckPrevReg;
  assign sckFall = !sckSync && sckPrevReg;


  // Leading edge leaves the idle level; trailing edge returns to it
  always_comb begin
    if (isMaster) begin
      leadEdge  = halfTick && (mStateReg == LEAD);
      trailEdge = halfTick && (mStateReg == TRAIL);
    end else begin
      leadEdge  = !slaveHold && (clockIdlePolarity ? sckFall : sckRise);
      trailEdge = !slaveHold && (clockIdlePolarity ? sckRise : sckFall);
    end
  end


  // Edge bit set: data driven ahead of the lead edge, shifted on trail; else shifted on lead
  // Sample at mid bit (opposite of shift edge) or, master only, at end of the bit time
  always_comb begin
    shiftEvt  = clockEdgeSelect ? trailEdge : leadEdge;
    sampleEvt = clockEdgeSelect ? leadEdge : trailEdge;
    if (isMaster && inputSamplePhase) begin
      sampleEvt = shiftEvt;
    end
  end
  assign lastSample = (bitCountReg == `BIT_LAST);


  // End-of-bit sampling takes the bit on the shift edge itself, after the final clock
  // A slave with the edge bit set finishes on the eighth trailing edge, from the held sample
  always_comb begin
    if (isMaster && inputSamplePhase) begin
      byteDone = activeReg && trailEdge && lastSample;
    end else begin
      byteDone = activeReg && lastSample && ((isMaster || !clockEdgeSelect) ? sampleEvt : trailEdge);
    end
  end


  assign acceptWrite = bufWrite && !activeReg && portEnable;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mStateReg <= IDLE;
    end else if (!portEnable || !isMaster) begin
      mStateReg <= IDLE;
    end else begin
      unique case (mStateReg)
        IDLE:  if (acceptWrite) mStateReg <= LEAD;
        LEAD:  if (halfTick) mStateReg <= TRAIL;
        TRAIL: if (halfTick) mStateReg <= (bitCountReg == `BIT_LAST) ? IDLE : LEAD;
      endcase
    end
  end


  // Slave is armed to shift whenever enabled and not deselected; master becomes active by a buffer write
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      activeReg <= 1'b0;
    end else if (isMaster) begin
      if (!portEnable) begin
        activeReg <= 1'b0;
      end else if (acceptWrite) begin
        activeReg <= 1'b1;
      end else if (halfTick && mStateReg == TRAIL && lastSample) begin
        activeReg <= 1'b0;
      end
    end else begin
      activeReg <= !slaveHold;
    end
  end
  assign xferBusy = isMaster ? activeReg : (activeReg && bitCountReg != 3'h0);

  // Status copy of the busy state lags by one cycle; write refusal uses the live term
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      busy <= 1'b0;
    end else begin
      busy <= xferBusy;
    end
  end

  // Shift register: loaded only through the buffer write path
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      portShiftReg  <= `BYTE_RESET;
      sampledBitReg <= 1'b0;
    end else if (bufWrite && !xferBusy && portEnable) begin
      portShiftReg  <= bufWriteData;
    end else if (activeReg) begin
      if (sampleEvt) begin
        sampledBitReg <= sdiSync;
      end
      if (isMaster && inputSamplePhase && shiftEvt) begin
        portShiftReg <= {portShiftReg[6:0], sdiSync};
      end else if (!(isMaster && inputSamplePhase) && shiftEvt) begin
        portShiftReg <= {portShiftReg[6:0], sampleEvt ? sdiSync : sampledBitReg};
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      bitCountReg <= 3'h0;
    end else if (slaveHold || (isMaster && !activeReg)) begin
      bitCountReg <= 3'h0;
    end else if (activeReg && trailEdge) begin
      bitCountReg <= bitCountReg + 3'h1;
    end
  end


  // Buffer copy uses the last bit's sample (live, or held for a slave with the edge bit set) so the byte is complete on this cycle
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      portDataBuffer <= `BYTE_RESET;
    end else if (byteDone) begin
      portDataBuffer <= (isMaster && inputSamplePhase) ? {portShiftReg[6:0], sdiSync}
                      : {portShiftReg[6:0], sampleEvt ? sdiSync : sampledBitReg};
    end
  end


  // Set wins over clear for every flag
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      bufferFullFlag <= 1'b0;
    end else if (byteDone) begin
      bufferFullFlag <= 1'b1;
    end else if (bufRead) begin
      bufferFullFlag <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      portIrqFlag <= 1'b0;
    end else if (byteDone) begin
      portIrqFlag <= 1'b1;
    end else if (irqClear) begin
      portIrqFlag <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wakeRequest <= 1'b0;
    end else begin
      wakeRequest <= byteDone && sleepActive && !isMaster;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      writeCollisionFlag <= 1'b0;
    end else if (bufWrite && xferBusy && portEnable) begin
      writeCollisionFlag <= 1'b1;
    end else if (collisionClear) begin
      writeCollisionFlag <= 1'b0;
    end
  end


  // Pins: direction override beyond enable is left to the port direction logic
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sckOut  <= 1'b0;
      sckOe_n <= 1'b1;
      sdoOut  <= 1'b0;
      sdoOe_n <= 1'b1;
    end else begin
      sckOe_n <= !(portEnable && isMaster);
      sckOut  <= clockIdlePolarity ^ (mStateReg == TRAIL);
      sdoOut  <= portShiftReg[7];
      sdoOe_n <= !(portEnable && !(selMode && selSync_n));
    end
  end

  a_full_on_done: assert property (@(posedge clk_sys) disable iff (!rst_n)
    byteDone |=> bufferFullFlag && portIrqFlag) else $error("byte done did not set flags");
  a_read_clears_full: assert property (@(posedge clk_sys) disable iff (!rst_n)
    bufRead && !byteDone |=> !bufferFullFlag) else $error("read did not clear full");
  a_collision_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
    bufWrite && xferBusy && portEnable |=> writeCollisionFlag) else $error("collision missed");
  a_collision_sticky: assert property (@(posedge clk_sys) disable iff (!rst_n)
    writeCollisionFlag && !collisionClear |=> writeCollisionFlag) else $error("collision lost");
  a_irq_sticky: assert property (@(posedge clk_sys) disable iff (!rst_n)
    portIrqFlag && !irqClear |=> portIrqFlag) else $error("irq flag dropped");
  a_buffer_kept: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !byteDone |=> $stable(portDataBuffer)) else $error("buffer changed outside done");
  a_select_release: assert property (@(posedge clk_sys) disable iff (!rst_n)
    selMode && selSync_n |=> sdoOe_n) else $error("data out still driven");
  a_hold_counter: assert property (@(posedge clk_sys) disable iff (!rst_n)
    slaveHold |=> bitCountReg == 3'h0) else $error("counter not cleared");
  a_master_starts: assert property (@(posedge clk_sys) disable iff (!rst_n)
    acceptWrite && isMaster |=> activeReg && mStateReg == LEAD) else $error("write did not start");
  a_idle_level: assert property (@(posedge clk_sys) disable iff (!rst_n)
    isMaster && mStateReg == IDLE |=> sckOut == $past(clockIdlePolarity))
    else $error("clock not idle");
  a_sleep_freeze: assert property (@(posedge clk_sys) disable iff (!rst_n)
    isMaster && sleepActive && portEnable && $past(sleepActive) |-> !halfTick)
    else $error("master ran in sleep");

  a_busy_registered: assert property (@(posedge clk_sys) disable iff (!rst_n)
    1'b1 |=> busy == $past(xferBusy)) else $error("busy status out of step");
  a_disable_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !portEnable |=> !activeReg) else $error("port active while disabled");
  a_shift_msb: assert property (@(posedge clk_sys) disable iff (!rst_n)
    activeReg && shiftEvt && !(bufWrite && !xferBusy && portEnable) |=> portShiftReg[7] == $past(portShiftReg[6]))
    else $error("shift not toward the top bit");
  a_sdo_msb: assert property (@(posedge clk_sys) disable iff (!rst_n)
    1'b1 |=> sdoOut == $past(portShiftReg[7])) else $error("data out not top bit");
  a_wake_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
    byteDone && sleepActive && !isMaster |=> wakeRequest) else $error("no wake on slave byte");
  a_bit_advance: assert property (@(posedge clk_sys) disable iff (!rst_n)
    activeReg && trailEdge && !slaveHold |=> bitCountReg == $past(bitCountReg) + 3'h1)
    else $error("bit counter did not advance");
  a_sck_owner: assert property (@(posedge clk_sys) disable iff (!rst_n)
    portEnable && isMaster |=> !sckOe_n) else $error("master clock not driven");

  c_master_byte: cover property (@(posedge clk_sys) disable iff (!rst_n) byteDone && isMaster);
  c_slave_byte:  cover property (@(posedge clk_sys) disable iff (!rst_n) byteDone && !isMaster);
  c_collision:   cover property (@(posedge clk_sys) disable iff (!rst_n) bufWrite && xferBusy);
  c_slave_wake:  cover property (@(posedge clk_sys) disable iff (!rst_n) wakeRequest);
endmodule

// ===== test/spi_peer_model.sv
/*
  External serial partner: a slave for master tests, a master for slave tests.
  Assumes the bench picks the role by calling load (slave) or xfer (master).
*/
`timescale 1ns/1ps
module spi_peer_model (
  input  wire logic sckOut,
  input  wire logic sdoOut,
  input  wire logic cpol,
  output logic      sdiPin,
  output logic      sckPinIn,
  output logic      selectPin_n
);
  logic [7:0] txReg;
  logic [7:0] rxReg;
  initial begin
    sdiPin = 1'b0;
    sckPinIn = 1'b0;
    selectPin_n = 1'b1;
  end
  // Capture on the leading edge, shift on the trailing one
  // Spent bits refill inverted so the line never shows a stale level
  always @(sckOut) begin
    if (sckOut !== cpol) begin
      rxReg = {rxReg[6:0], sdoOut};
    end else begin
      txReg = {txReg[6:0], ~txReg[7]};
      sdiPin = txReg[7];
    end
  end
  task load(input logic [7:0] b);
    txReg = b;
    sdiPin = b[7];
  endtask
  // Master role: 33 ns half period, unrelated to clk_sys, MSB first
  task xfer(input logic [7:0] b, input int bits);
    txReg = b;
    selectPin_n = 1'b0;
    for (int i = 0; i < bits; i++) begin
      sdiPin = txReg[7];
      #33 sckPinIn = 1'b1;
      rxReg = {rxReg[6:0], sdoOut};
      txReg = txReg << 1;
      #33 sckPinIn = 1'b0;
    end
    #40 selectPin_n = 1'b1;
    sdiPin = ~sdiPin;
  endtask
endmodule

// ===== test/testbench.sv
/*
  Self-checking bench of the serial port: master and slave transfers against the peer.
  Assumes the design files and the map header are compiled first.
*/
`timescale 1ns/1ps
`include "spi_port_map.svh"
module testbench;
  import spi_port_pkg::*;
  logic       clk_sys, rst_n, portEnable, cpol, samplePhase, edgeSel, sleepActive, timerTick;
  logic       bufWrite, bufRead, irqClear, collisionClear, fullF, irqF, colF, wake, busy;
  logic       sdoOut, sdoOe_n, sckOut, sdiPin, sckPinIn, selectPin_n, sckLast, wakeSeen, sckOe_n;
  logic [3:0] mode, tickCnt;
  byte_t      wrData, buffer;
  int         errCount, totalChecks, halfLen, runLen, togs, t;
  int         half[4] = '{2, 8, 32, 10};

  spi_master_slave_port DUT (.clk_sys(clk_sys), .rst_n(rst_n), .portEnable(portEnable),
    .clockIdlePolarity(cpol), .portModeSelect(mode), .inputSamplePhase(samplePhase),
    .clockEdgeSelect(edgeSel), .sleepActive(sleepActive), .timerTick(timerTick),
    .bufWrite(bufWrite), .bufWriteData(wrData), .bufRead(bufRead), .irqClear(irqClear),
    .collisionClear(collisionClear), .sdiPin(sdiPin), .sckPinIn(sckPinIn),
    .selectPin_n(selectPin_n), .portDataBuffer(buffer), .bufferFullFlag(fullF),
    .portIrqFlag(irqF), .writeCollisionFlag(colF), .wakeRequest(wake), .busy(busy),
    .sdoOut(sdoOut), .sdoOe_n(sdoOe_n), .sckOut(sckOut), .sckOe_n(sckOe_n));
  spi_peer_model peer (.sckOut(sckOut), .sdoOut(sdoOut), .cpol(cpol), .sdiPin(sdiPin),
    .sckPinIn(sckPinIn), .selectPin_n(selectPin_n));

  always #2 clk_sys = ~clk_sys;
  // Half-period meter on the master clock, plus a timer tick every 10 cycles
  always @(posedge clk_sys) begin
    sckLast <= sckOut;
    wakeSeen <= wakeSeen | (wake === 1'b1);
    tickCnt <= (tickCnt == 4'h9) ? 4'h0 : tickCnt + 4'h1;
    timerTick <= #1 (tickCnt == 4'h9);
    if (sckOut !== sckLast) begin
      halfLen <= runLen;
      runLen <= 1;
      togs <= togs + 1;
    end else begin
      runLen <= runLen + 1;
    end
  end
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      errCount++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task testDone;
    $display("Checks %0d errors %0d", totalChecks, errCount);
    if (errCount == 0 && totalChecks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task wr(input byte_t d);
    bufWrite = 1'b1;
    wrData = d;
    cyc(1);
    bufWrite = 1'b0;
  endtask
  task waitIdle;
    int n;
    n = 0;
    // Busy status is registered, so let it rise first
    cyc(1);
    while (busy !== 1'b0 && n < 2000) begin
      cyc(1);
      n++;
    end
    if (n == 2000) begin
      errCount++;
      testDone;
    end
    cyc(2);
  endtask
  // Reconfigure with the enable off, draining the buffer first
  task cfg(input logic [3:0] m, input logic p);
    portEnable = 1'b0;
    bufRead = 1'b1;
    cyc(1);
    bufRead = 1'b0;
    mode = m;
    cpol = p;
    cyc(2);
    portEnable = 1'b1;
    cyc(4);
  endtask
  task mxfer(input byte_t tx, input byte_t rx);
    peer.load(rx);
    wr(tx);
    waitIdle;
    check("peer rx", peer.rxReg, tx);
  endtask

  initial begin
    {clk_sys, rst_n, portEnable, cpol, samplePhase, sleepActive, timerTick} = '0;
    {bufWrite, bufRead, irqClear, collisionClear, sckLast, wakeSeen} = '0;
    {edgeSel, mode, tickCnt, wrData, errCount, totalChecks, halfLen, runLen, togs} = '0;
    edgeSel = 1'b1;
    cyc(20);
    rst_n = 1'b1;
    cyc(1);
    check("reset state", {buffer, fullF, irqF, colF, sdoOe_n}, 12'h001);
    cfg(4'h1, 1'b0);
    mxfer(8'ha5, 8'h3c);
    check("rx byte", {buffer, fullF, irqF}, 10'h0f3);
    peer.load(8'h81);
    wr(8'h5a);
    cyc(4);
    wr(8'hff);
    cyc(2);
    check("collision", colF, 1'b1);
    waitIdle;
    check("kept byte", peer.rxReg, 8'h5a);
    check("next byte", buffer, 8'h81);
    bufRead = 1'b1;
    cyc(1);
    bufRead = 1'b0;
    cyc(1);
    check("read clears full", {fullF, irqF, colF}, 3'b011);
    irqClear = 1'b1;
    collisionClear = 1'b1;
    cyc(1);
    {irqClear, collisionClear} = 2'b00;
    cyc(1);
    check("flags cleared", {irqF, colF}, 2'b00);
    peer.load(8'hc3);
    wr(8'h96);
    cyc(10);
    sleepActive = 1'b1;
    cyc(2);
    t = togs;
    cyc(40);
    check("sleep freeze", togs, t);
    sleepActive = 1'b0;
    waitIdle;
    check("resume", {peer.rxReg, buffer}, 16'h96c3);
    for (int i = 0; i < 4; i++) begin
      cfg(4'(i), i[0]);
      check("sck idle", sckOut, i[0]);
      check("sck owned", sckOe_n, 1'b0);
      mxfer(8'h69 + 8'(i), 8'h00);
      check("half period", halfLen, half[i]);
    end
    samplePhase = 1'b1;
    cfg(4'h1, 1'b0);
    mxfer(8'h5c, 8'h2b);
    check("end sample", buffer, 8'h2b);
    samplePhase = 1'b0;
    wr(8'h3c);
    cyc(6);
    portEnable = 1'b0;
    cyc(2);
    check("disable abort", busy, 1'b0);
    cfg(4'h4, 1'b0);
    check("unselected", sdoOe_n, 1'b1);
    check("slave sck input", sckOe_n, 1'b1);
    wr(8'he7);
    peer.xfer(8'h11, 4);
    cyc(4);
    check("select abort", {sdoOe_n, busy, fullF}, 3'b100);
    sleepActive = 1'b1;
    peer.selectPin_n = 1'b0;
    cyc(5);
    check("selected", sdoOe_n, 1'b0);
    wr(8'hb4);
    peer.xfer(8'h4d, 8);
    cyc(6);
    check("slave tx", peer.rxReg, 8'hb4);
    check("slave rx", {buffer, fullF, irqF}, 10'h137);
    check("wake", wakeSeen, 1'b1);
    testDone;
  end
endmodule
